// ---- src/ipc_consts.svh ----
`ifndef IPC_CONSTS_SVH
`define IPC_CONSTS_SVH
// register byte offsets
`define IPC_OFF_CTRL 12'h000
`define IPC_OFF_MASK 12'h004
`define IPC_OFF_TRIG 12'h008
`define IPC_OFF_PRIO 12'h00C
`define IPC_OFF_VECT 12'h010
`define IPC_OFF_CPU 12'h014
`define IPC_OFF_INSV 12'h018
`define IPC_OFF_EOI 12'h01C
`define IPC_OFF_STAT 12'h020
`define IPC_OFF_IEN 12'h024
`define IPC_OFF_ICLR 12'h028
// ctrl field positions
`define IPC_CTRL_CAS0 0
`define IPC_CTRL_CAS1 1
`define IPC_CTRL_SLAVE 2
// cpu register: bit0 interrupt-enable flag, bit1 boundary strobe (write-only)
`define IPC_CPU_IF 0
`define IPC_CPU_BND 1
// vector entries
`define IPC_VEC_NMI 8'h02
`define IPC_VEC_BASE 8'h0C
// reset values
`define IPC_MASK_RST 5'h1F
`define IPC_PRIO_RST 15'h7FFF
// edges after reset until the synchronisers hold real pin levels
`define IPC_SYNC_FILL 2'h3
// status bits
`define IPC_ST_TAKEN 0
`define IPC_ST_NMI 1
`endif

// ---- src/ipc_pkg.sv ----
package ipc_pkg;
  typedef enum logic [2:0] {
    IPC_IDLE = 3'h1,
    IPC_ACK = 3'h2,
    IPC_SEL = 3'h4
  } ipc_state_t;
endpackage

// ---- src/ipc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// two-flop synchroniser, one per bit
module ipc_sync #(parameter int W = 1)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  // first flop read only by the second
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  assign dout = s2_q;
endmodule // ipc_sync
`default_nettype wire

// ---- src/ipc_top.sv ----
// Notes on behaviour
// - unmasked maskable request vectors to its own table entry
// - each request synchronised; edge or level trigger per input
// - cascade on request zero turns request two into acknowledge zero
// - acknowledge output asks the peripheral for the interrupt type
// - slave mode: select input marks type present on bus
// - slave mode: request three pin becomes request toward master
// - non-maskable input highest priority, always to its entry
// - non-maskable has no request or in-service bit
// - taking any interrupt clears the interrupt-enable flag
// - non-maskable in service never affects maskable resolution
// - non-maskable rising edge latched, taken at instruction boundary
// - non-maskable high through reset does not fire
// - request zero behaves like the other maskable inputs unless cascade zero or slave mode is set
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ipc_consts.svh"
module ipc_top #(parameter int NREQ = 5)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] maskable_request_in,
  input wire logic nmi_in,
  input wire logic select_in,
  input wire logic [7:0] bus_type_in,
  output logic cascade_ack_zero,
  output logic cascade_ack_one,
  output logic cascade_ack_zero_oe,
  output logic cascade_ack_one_oe,
  output logic slave_irq,
  output logic take_pulse,
  output logic [7:0] take_vector,
  output logic irq
);
  // =====================================================================
  // input synchronisers
  logic [4:0] req_s;
  logic nmi_s;
  logic sel_s;
  ipc_sync #(.W(7)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({select_in, nmi_in, maskable_request_in}),
    .dout({sel_s, nmi_s, req_s})
  );
  // =====================================================================
  // registers
  logic [2:0] ctrl_q, ctrl_d;
  logic [4:0] mask_q, mask_d, trig_q, trig_d, pend_q, pend_d, insv_q, insv_d;
  logic [14:0] prio_q, prio_d;
  logic [7:0] vect_q, vect_d;
  logic if_q, if_d, nmi_pend_q, nmi_pend_d, nmi_arm_q, nmi_arm_d, nmi_prev_q, nmi_prev_d;
  logic [4:0] req_prev_q, req_prev_d;
  logic [1:0] st_q, st_d, ien_q, ien_d;
  logic [31:0] prdata_d;
  logic pready_d, take_d, ack0_d, ack1_d, sirq_d, irq_d;
  logic oe0_d, oe1_d;
  logic [1:0] warm_q, warm_d;
  logic [7:0] tvec_d;
  ipc_pkg::ipc_state_t fsm_q, fsm_d;
  logic [2:0] src_q, src_d;
  logic wr, rd, bnd;
  logic [4:0] cand;
  logic [2:0] best;
  logic [2:0] best_lvl;
  logic have;
  assign wr = psel && penable && pwrite && !pready;
  assign rd = psel && penable && !pwrite && !pready;
  assign bnd = wr && paddr == `IPC_OFF_CPU && pwdata[`IPC_CPU_BND];
  // =====================================================================
  // priority pick among unmasked pending, lowest level wins, lower index on tie
  always_comb
  begin
    cand = pend_q & ~mask_q & ~insv_q;
    if (ctrl_q[`IPC_CTRL_CAS0]) cand[2] = 1'b0;
    if (ctrl_q[`IPC_CTRL_CAS1] || ctrl_q[`IPC_CTRL_SLAVE]) cand[3] = 1'b0;
    if (ctrl_q[`IPC_CTRL_SLAVE]) cand[4:1] = 4'h0;
    have = 1'b0;
    best = 3'h0;
    best_lvl = 3'h7;
    for (int i = NREQ - 1; i >= 0; i--)
    begin
      if (cand[i] && prio_q[i*3 +: 3] <= best_lvl)
      begin
        have = 1'b1;
        best = 3'(i);
        best_lvl = prio_q[i*3 +: 3];
      end
    end
  end
  // =====================================================================
  // next-state logic
  always_comb
  begin
    ctrl_d = ctrl_q; mask_d = mask_q; trig_d = trig_q; prio_d = prio_q;
    vect_d = vect_q; if_d = if_q; insv_d = insv_q; st_d = st_q; ien_d = ien_q;
    fsm_d = fsm_q; src_d = src_q; take_d = 1'b0; tvec_d = take_vector;
    pready_d = psel && penable && !pready;
    prdata_d = prdata;
    req_prev_d = req_s;
    nmi_prev_d = nmi_s;
    // request capture: edge sets sticky, level follows pin
    for (int i = 0; i < NREQ; i++)
      pend_d[i] = trig_q[i] ? (pend_q[i] | (req_s[i] & ~req_prev_q[i])) : req_s[i];
    // synchroniser flops leave reset low, so a pin held high would look
    // like a rising edge; arm only on a low seen once the flops are filled
    warm_d = warm_q + {1'b0, warm_q != `IPC_SYNC_FILL};
    nmi_arm_d = nmi_arm_q | ((warm_q == `IPC_SYNC_FILL) & ~nmi_s);
    nmi_pend_d = nmi_pend_q | (nmi_arm_q & nmi_s & ~nmi_prev_q);
    // software writes
    if (wr)
    begin
      unique case (paddr)
        `IPC_OFF_CTRL: ctrl_d = pwdata[2:0];
        `IPC_OFF_MASK: mask_d = pwdata[4:0];
        `IPC_OFF_TRIG: trig_d = pwdata[4:0];
        `IPC_OFF_PRIO: prio_d = pwdata[14:0];
        `IPC_OFF_VECT: vect_d = pwdata[7:0];
        `IPC_OFF_CPU: if_d = pwdata[`IPC_CPU_IF];
        `IPC_OFF_EOI: insv_d = insv_q & ~pwdata[4:0];
        `IPC_OFF_IEN: ien_d = pwdata[1:0];
        `IPC_OFF_ICLR: st_d = st_q & ~pwdata[1:0];
        default: ;
      endcase
    end
    if (rd)
    begin
      unique case (paddr)
        `IPC_OFF_CTRL: prdata_d = {29'h0, ctrl_q};
        `IPC_OFF_MASK: prdata_d = {27'h0, mask_q};
        `IPC_OFF_TRIG: prdata_d = {27'h0, trig_q};
        `IPC_OFF_PRIO: prdata_d = {17'h0, prio_q};
        `IPC_OFF_VECT: prdata_d = {24'h0, vect_q};
        `IPC_OFF_CPU: prdata_d = {31'h0, if_q};
        `IPC_OFF_INSV: prdata_d = {27'h0, insv_q};
        `IPC_OFF_STAT: prdata_d = {30'h0, st_q};
        `IPC_OFF_IEN: prdata_d = {30'h0, ien_q};
        default: prdata_d = 32'h0;
      endcase
    end
    // take at an instruction boundary; nmi first, never masked
    if (bnd && fsm_q == ipc_pkg::IPC_IDLE)
    begin
      if (nmi_pend_q)
      begin
        nmi_pend_d = 1'b0;
        take_d = 1'b1;
        tvec_d = `IPC_VEC_NMI;
        if_d = 1'b0;
        st_d[`IPC_ST_NMI] = 1'b1;
      end
      else if (if_q && have)
      begin
        src_d = best;
        if ((best == 3'h0 && (ctrl_q[`IPC_CTRL_CAS0] || ctrl_q[`IPC_CTRL_SLAVE]))
            || (best == 3'h1 && ctrl_q[`IPC_CTRL_CAS1]))
          fsm_d = ipc_pkg::IPC_ACK;
        else
        begin
          take_d = 1'b1;
          tvec_d = 8'(`IPC_VEC_BASE + {5'h0, best});
          if_d = 1'b0;
          insv_d[best] = 1'b1;
          if (trig_q[best]) pend_d[best] = 1'b0;
          st_d[`IPC_ST_TAKEN] = 1'b1;
        end
      end
    end
    // acknowledge / select wait for the type off the bus
    unique case (fsm_q)
      ipc_pkg::IPC_IDLE: ;
      ipc_pkg::IPC_ACK:
      begin
        if (!ctrl_q[`IPC_CTRL_SLAVE] || sel_s) fsm_d = ipc_pkg::IPC_SEL;
      end
      ipc_pkg::IPC_SEL:
      begin
        fsm_d = ipc_pkg::IPC_IDLE;
        take_d = 1'b1;
        tvec_d = bus_type_in;
        if_d = 1'b0;
        insv_d[src_q] = 1'b1;
        if (trig_q[src_q]) pend_d[src_q] = 1'b0;
        st_d[`IPC_ST_TAKEN] = 1'b1;
      end
      default: fsm_d = ipc_pkg::IPC_IDLE;
    endcase
    // outputs; acknowledge held through ACK and SEL states
    ack0_d = ctrl_d[`IPC_CTRL_CAS0] && !ctrl_d[`IPC_CTRL_SLAVE] && fsm_d != ipc_pkg::IPC_IDLE
             && src_d == 3'h0;
    ack1_d = ctrl_d[`IPC_CTRL_CAS1] && !ctrl_d[`IPC_CTRL_SLAVE] && fsm_d != ipc_pkg::IPC_IDLE
             && src_d == 3'h1;
    // pin direction follows the mode being written, same as the acknowledge
    oe0_d = ctrl_d[`IPC_CTRL_CAS0] && !ctrl_d[`IPC_CTRL_SLAVE];
    oe1_d = ctrl_d[`IPC_CTRL_CAS1] || ctrl_d[`IPC_CTRL_SLAVE];
    sirq_d = ctrl_q[`IPC_CTRL_SLAVE] && (nmi_pend_q || have);
    irq_d = |(st_d & ien_d);
  end
  // =====================================================================
  // state registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= 3'h0; mask_q <= `IPC_MASK_RST; trig_q <= 5'h1F; prio_q <= `IPC_PRIO_RST;
      vect_q <= 8'h00; if_q <= 1'b0; insv_q <= 5'h00; pend_q <= 5'h00; st_q <= 2'h0;
      ien_q <= 2'h0; nmi_pend_q <= 1'b0; nmi_arm_q <= 1'b0; nmi_prev_q <= 1'b0;
      req_prev_q <= 5'h00; fsm_q <= ipc_pkg::IPC_IDLE; src_q <= 3'h0;
      prdata <= 32'h0; pready <= 1'b0; take_pulse <= 1'b0; take_vector <= 8'h00;
      cascade_ack_zero <= 1'b0; cascade_ack_one <= 1'b0; slave_irq <= 1'b0; irq <= 1'b0;
      cascade_ack_zero_oe <= 1'b0; cascade_ack_one_oe <= 1'b0;
      warm_q <= 2'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d; mask_q <= mask_d; trig_q <= trig_d; prio_q <= prio_d;
      vect_q <= vect_d; if_q <= if_d; insv_q <= insv_d; pend_q <= pend_d; st_q <= st_d;
      ien_q <= ien_d; nmi_pend_q <= nmi_pend_d; nmi_arm_q <= nmi_arm_d; nmi_prev_q <= nmi_prev_d;
      req_prev_q <= req_prev_d; fsm_q <= fsm_d; src_q <= src_d;
      prdata <= prdata_d; pready <= pready_d; take_pulse <= take_d; take_vector <= tvec_d;
      cascade_ack_zero <= ack0_d; cascade_ack_one <= ack1_d; slave_irq <= sirq_d; irq <= irq_d;
      cascade_ack_zero_oe <= oe0_d;
      cascade_ack_one_oe <= oe1_d;
      warm_q <= warm_d;
      // no error response: unmapped accesses are ignored quietly
      pslverr <= 1'b0;
    end
  end
  // =====================================================================
  // assertions
  property p_take_clears_if;
    @(posedge clk) disable iff (sys_rst) take_pulse |-> !if_q;
  endproperty
  a_take_clears_if: assert property (p_take_clears_if) else $error("flag not cleared");
  property p_nmi_vec;
    @(posedge clk) disable iff (sys_rst)
      (bnd && fsm_q == ipc_pkg::IPC_IDLE && nmi_pend_q) |=> (take_pulse && take_vector == 8'h02);
  endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("nmi not taken");
  property p_nmi_no_reset_fire;
    @(posedge clk) disable iff (sys_rst) !nmi_arm_q |=> !nmi_pend_q;
  endproperty
  a_nmi_no_reset_fire: assert property (p_nmi_no_reset_fire) else $error("nmi fired from level");
  property p_nmi_edge;
    @(posedge clk) disable iff (sys_rst) $rose(nmi_pend_q) |-> $past(nmi_s) && !$past(nmi_prev_q);
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("nmi without edge");
  property p_if_gate;
    @(posedge clk) disable iff (sys_rst)
      (bnd && fsm_q == ipc_pkg::IPC_IDLE && !nmi_pend_q && !if_q) |=> !take_pulse;
  endproperty
  a_if_gate: assert property (p_if_gate) else $error("taken while disabled");
  property p_vec_index;
    @(posedge clk) disable iff (sys_rst)
      (bnd && fsm_q == ipc_pkg::IPC_IDLE && !nmi_pend_q && if_q && have && best == 3'h4)
      |=> take_vector == 8'h10;
  endproperty
  a_vec_index: assert property (p_vec_index) else $error("wrong vector");
  property p_ack_type;
    @(posedge clk) disable iff (sys_rst)
      (fsm_q == ipc_pkg::IPC_SEL) |=> (take_pulse && take_vector == $past(bus_type_in));
  endproperty
  a_ack_type: assert property (p_ack_type) else $error("type not used");
  property p_sel_wait;
    @(posedge clk) disable iff (sys_rst)
      (fsm_q == ipc_pkg::IPC_ACK && ctrl_q[`IPC_CTRL_SLAVE] && !sel_s) |=> fsm_q == ipc_pkg::IPC_ACK;
  endproperty
  a_sel_wait: assert property (p_sel_wait) else $error("select ignored");
  property p_one_insv;
    @(posedge clk) disable iff (sys_rst) take_pulse |-> $countones(insv_q ^ $past(insv_q)) <= 1;
  endproperty
  a_one_insv: assert property (p_one_insv) else $error("two in service at once");
  c_nmi: cover property (@(posedge clk) disable iff (sys_rst) take_pulse && take_vector == 8'h02);
  c_casc: cover property (@(posedge clk) disable iff (sys_rst) cascade_ack_zero ##2 take_pulse);
  c_slave: cover property (@(posedge clk) disable iff (sys_rst) slave_irq ##[1:20] take_pulse);
  c_casc1: cover property (@(posedge clk) disable iff (sys_rst) cascade_ack_one ##2 take_pulse);
  // nothing arms before the synchronisers carry real pin levels
  property p_nmi_warm;
    @(posedge clk) disable iff (sys_rst) (warm_q != `IPC_SYNC_FILL) |-> !nmi_arm_q;
  endproperty
  a_nmi_warm: assert property (p_nmi_warm) else $error("nmi armed during fill");
  // acknowledge only shows on a pin that is turned outward
  property p_ack0_oe;
    @(posedge clk) disable iff (sys_rst) cascade_ack_zero |-> cascade_ack_zero_oe;
  endproperty
  a_ack0_oe: assert property (p_ack0_oe) else $error("ack zero on input pin");
  property p_ack1_oe;
    @(posedge clk) disable iff (sys_rst) cascade_ack_one |-> cascade_ack_one_oe;
  endproperty
  a_ack1_oe: assert property (p_ack1_oe) else $error("ack one on input pin");
  // a pending unmasked request zero in slave mode is raised toward the master
  property p_slave_raise;
    @(posedge clk) disable iff (sys_rst) (ctrl_q[`IPC_CTRL_SLAVE] && have) |=> slave_irq;
  endproperty
  a_slave_raise: assert property (p_slave_raise) else $error("slave request not raised");
endmodule // ipc_top
`default_nettype wire

// ---- tb/ipc_peer.sv ----
`timescale 1ns/10ps
`default_nettype none
// =====================================
// far side: requesting peripherals and master controller
module ipc_peer
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] req_lvl,
  input wire logic nmi_lvl,
  input wire logic slave_go,
  input wire logic [7:0] type_val,
  input wire logic ack0,
  input wire logic ack1,
  input wire logic ack0_oe,
  input wire logic ack1_oe,
  input wire logic slv_irq,
  input wire logic take,
  output logic [4:0] req_pin,
  output logic nmi_pin,
  output logic sel_pin,
  output logic [7:0] type_pin
);
  logic [2:0] sel_cnt_q;
  logic slv_q;
  logic [7:0] pat_q;
  // master raises request zero, select follows three cycles later
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
      {slv_q, sel_cnt_q, pat_q} <= 12'h000;
    else
    begin
      pat_q <= ~pat_q;
      if (slave_go)
        slv_q <= 1'b1;
      else if (take)
        slv_q <= 1'b0;
      sel_cnt_q <= slv_q ? sel_cnt_q + {2'h0, sel_cnt_q != 3'h3} : 3'h0;
    end
  // pin levels worked out from the controller's output enables
  assign req_pin[0] = req_lvl[0] | slv_q;
  assign req_pin[1] = req_lvl[1];
  assign req_pin[2] = ack0_oe ? ack0 : req_lvl[2];
  assign req_pin[3] = ack1_oe ? (ack1 | slv_irq) : req_lvl[3];
  assign req_pin[4] = req_lvl[4];
  assign nmi_pin = nmi_lvl;
  assign sel_pin = sel_cnt_q == 3'h3;
  // type byte only while asked for, else a changing pattern
  assign type_pin = (ack0 | ack1 | sel_pin) ? type_val : pat_q;
endmodule // ipc_peer
`default_nettype wire

// ---- tb/interrupt_pin_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ipc_consts.svh"
module interrupt_pin_control_tb;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, nmi_lvl, slave_go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ack0, ack1, ack0_oe, ack1_oe, slv_irq, take, irq, nmi_pin, sel_pin;
  logic [7:0] vec, type_pin, type_val;
  logic [4:0] req_pin, req_lvl;
  logic [1:0] ackseen;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  // =====================================
  // instances
  ipc_top #(.NREQ(5)) ipc_top_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .maskable_request_in(req_pin), .nmi_in(nmi_pin),
    .select_in(sel_pin), .bus_type_in(type_pin), .cascade_ack_zero(ack0),
    .cascade_ack_one(ack1), .cascade_ack_zero_oe(ack0_oe), .cascade_ack_one_oe(ack1_oe),
    .slave_irq(slv_irq), .take_pulse(take), .take_vector(vec), .irq(irq));
  ipc_peer ipc_peer_inst (.clk(clk), .sys_rst(sys_rst), .req_lvl(req_lvl),
    .nmi_lvl(nmi_lvl), .slave_go(slave_go), .type_val(type_val), .ack0(ack0), .ack1(ack1),
    .ack0_oe(ack0_oe), .ack1_oe(ack1_oe), .slv_irq(slv_irq), .take(take),
    .req_pin(req_pin), .nmi_pin(nmi_pin), .sel_pin(sel_pin), .type_pin(type_pin));
  // =====================================
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      summarize();
    end
  end
  // =====================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
    chk("slverr", 32'h0, {31'h0, pslverr});
  endtask
  // boundary write, then watch for a take
  task automatic tk(input logic [31:0] cpu, input logic ex, input logic [7:0] ev);
    logic seen;
    // flag first, so the boundary write sees the intended enable
    wr(`IPC_OFF_CPU, cpu & 32'h1);
    wr(`IPC_OFF_CPU, cpu);
    // a direct take stands in the cycle in which the write completes
    seen = take;
    ackseen = {ack1, ack0};
    repeat (12)
    begin
      @(posedge clk);
      seen |= take;
      ackseen |= {ack1, ack0};
    end
    chk("take", {31'h0, ex}, {31'h0, seen});
    if (ex)
      chk("vector", {24'h0, ev}, {24'h0, vec});
  endtask
  // =====================================
  // scenarios
  task automatic t_reset;
    rdchk("mask", `IPC_OFF_MASK, 32'h1F);
    rdchk("prio", `IPC_OFF_PRIO, 32'h7FFF);
    rdchk("trig", `IPC_OFF_TRIG, 32'h1F);
    rdchk("unmapped", 12'h040, 32'h0);
    tk(32'h3, 1'b0, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_vec;
    req_lvl <= 5'h1F;
    repeat (4) @(posedge clk);
    tk(32'h3, 1'b0, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(`IPC_OFF_MASK, 32'h1F & ~(32'h1 << i));
      tk(32'h3, 1'b1, `IPC_VEC_BASE + 8'(i));
      apb(1'b0, `IPC_OFF_CPU, 32'h0);
      chk("flag", 32'h0, {31'h0, rd[0]});
      wr(`IPC_OFF_EOI, 32'h1F);
    end
    req_lvl <= 5'h00;
    $display("vector test done");
  endtask
  task automatic t_prio;
    wr(`IPC_OFF_MASK, 32'h0);
    wr(`IPC_OFF_PRIO, 32'h71FF);
    req_lvl <= 5'h0A;
    repeat (4) @(posedge clk);
    tk(32'h2, 1'b0, 8'h00);
    tk(32'h3, 1'b1, `IPC_VEC_BASE + 8'h3);
    wr(`IPC_OFF_EOI, 32'h1F);
    tk(32'h3, 1'b1, `IPC_VEC_BASE + 8'h1);
    wr(`IPC_OFF_EOI, 32'h1F);
    // drop line one so its next rise is a fresh edge
    req_lvl <= 5'h00;
    wr(`IPC_OFF_TRIG, 32'h0F);
    req_lvl <= 5'h12;
    repeat (4) @(posedge clk);
    req_lvl <= 5'h00;
    repeat (4) @(posedge clk);
    tk(32'h3, 1'b1, `IPC_VEC_BASE + 8'h1);
    wr(`IPC_OFF_EOI, 32'h1F);
    tk(32'h3, 1'b0, 8'h00);
    $display("priority test done");
  endtask
  task automatic t_nmi;
    wr(`IPC_OFF_MASK, 32'h1F);
    nmi_lvl <= 1'b0;
    repeat (3) @(posedge clk);
    nmi_lvl <= 1'b1;
    repeat (4) @(posedge clk);
    tk(32'h2, 1'b1, `IPC_VEC_NMI);
    rdchk("insv", `IPC_OFF_INSV, 32'h0);
    nmi_lvl <= 1'b0;
    repeat (3) @(posedge clk);
    nmi_lvl <= 1'b1;
    repeat (4) @(posedge clk);
    tk(32'h2, 1'b1, `IPC_VEC_NMI);
    wr(`IPC_OFF_MASK, 32'h0);
    req_lvl <= 5'h01;
    repeat (4) @(posedge clk);
    tk(32'h3, 1'b1, `IPC_VEC_BASE);
    req_lvl <= 5'h00;
    wr(`IPC_OFF_EOI, 32'h1F);
    $display("nmi test done");
  endtask
  task automatic t_casc;
    wr(`IPC_OFF_CTRL, 32'h3);
    type_val <= 8'h42;
    req_lvl <= 5'h01;
    repeat (4) @(posedge clk);
    tk(32'h3, 1'b1, 8'h42);
    chk("ack", 32'h1, {30'h0, ackseen});
    chk("oe", 32'h3, {30'h0, ack1_oe, ack0_oe});
    req_lvl <= 5'h02;
    type_val <= 8'h37;
    wr(`IPC_OFF_EOI, 32'h1F);
    tk(32'h3, 1'b1, 8'h37);
    chk("ack", 32'h2, {30'h0, ackseen});
    req_lvl <= 5'h00;
    wr(`IPC_OFF_EOI, 32'h1F);
    $display("cascade test done");
  endtask
  task automatic t_slave;
    wr(`IPC_OFF_CTRL, 32'h4);
    repeat (3) @(posedge clk);
    chk("oe", 32'h2, {30'h0, ack1_oe, ack0_oe});
    type_val <= 8'h99;
    slave_go <= 1'b1;
    @(posedge clk);
    slave_go <= 1'b0;
    repeat (6) @(posedge clk);
    chk("slave irq", 32'h1, {31'h0, slv_irq});
    tk(32'h3, 1'b1, 8'h99);
    chk("slave irq", 32'h0, {31'h0, slv_irq});
    wr(`IPC_OFF_EOI, 32'h1F);
    $display("slave test done");
  endtask
  task automatic t_irq;
    rdchk("stat", `IPC_OFF_STAT, 32'h3);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`IPC_OFF_IEN, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`IPC_OFF_ICLR, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    rdchk("stat", `IPC_OFF_STAT, 32'h2);
    $display("status test done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // =====================================
  // main sequence
  initial
  begin
    {psel, penable, pwrite, slave_go} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    req_lvl = 5'h00;
    nmi_lvl = 1'b1;
    type_val = 8'h00;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_vec();
    t_prio();
    t_nmi();
    t_casc();
    t_slave();
    t_irq();
    summarize();
  end
endmodule // interrupt_pin_control_tb
`default_nettype wire
